/* pkg/intc_defines.svh */
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH
// register offsets on the plain port
`define OFF_CONFIG 8'h00
`define OFF_PENDING 8'h04
`define OFF_MASK 8'h08
`define OFF_IRQ_STATUS 8'h0c
`define OFF_EVENT_CLEAR 8'h10
// config field positions
`define CFG_PROMOTE_LSB 8
`define CFG_VBASE_LSB 13
`define CFG_SPREAD_BIT 0
`define CFG_RESET 24'h001f00
`define PROMOTE_NONE 5'h1f
`define UNINIT_VECTOR 8'h0f
`define ERROR_VECTOR_NUM 5'h00
// irq status bits
`define IRQ_ERROR_BIT 0
`define IRQ_ACK_BIT 1
`endif

/* pkg/intc_pkg.sv */
package intc_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [2:0] vector_base_bits;
    logic vbase_written;
    logic [4:0] promoted_source_number;
    logic spread;
  } cfg_t;
  typedef enum logic [1:0] {ack_idle, ack_done} ack_state_t;
endpackage

/* rtl/prio_select.sv */
`timescale 1ns/100ps
`include "intc_defines.svh"
// picks the highest priority pending source; pure combinational
module prio_select #(
  parameter int N = 32
) (
  input wire logic [N-1:0] pending,                 // pending flags
  input wire logic [4:0] promoted_source_number,    // promoted source
  input wire logic spread,                          // channel placement
  output logic found,                               // any pending
  output logic [4:0] winner                         // chosen source
);
  // table and winner width are built for exactly 32 sources
  if (N != 32) begin : g_bad_n
    $error("prio_select needs 32 sources");
  end
  // default order: bit 31 highest down to bit 0; serial channels 30..27.
  // spread mode walks a table that interleaves the channels among others.
  localparam logic [159:0] SPREAD_ORDER = {
    5'd31, 5'd30, 5'd26, 5'd25, 5'd29, 5'd24, 5'd23, 5'd22,
    5'd28, 5'd21, 5'd20, 5'd19, 5'd27, 5'd18, 5'd17, 5'd16,
    5'd15, 5'd14, 5'd13, 5'd12, 5'd11, 5'd10, 5'd9, 5'd8,
    5'd7, 5'd6, 5'd5, 5'd4, 5'd3, 5'd2, 5'd1, 5'd0};
  always_comb begin
    logic [4:0] idx;
    idx = 5'h00;
    found = 1'b0;
    winner = 5'h00;
    for (int i = 0; i < 32; i++) begin
      idx = spread ? SPREAD_ORDER[159-5*i -: 5] : 5'(31 - i);
      if (!found && pending[idx]) begin
        found = 1'b1;
        winner = idx;
      end
    end
    // promotion overrides the table unless all ones [RULE1] [RULE2]
    if (promoted_source_number != `PROMOTE_NONE && pending[promoted_source_number]) begin
      found = 1'b1;
      winner = promoted_source_number;
    end
  end
endmodule // prio_select

/* rtl/comm_module_interrupt_controller.sv */
// Functional notes
// RULE1 - a 5-bit config field names one source promoted to highest priority
// RULE2 - promoted field all ones keeps default priority order
// RULE3 - vector is three base bits above five-bit source number
// RULE4 - before base bits written, every source returns vector 0x0f
// RULE5 - spread bit 0 groups serial channels on top, 1 spreads them
// RULE6 - software may change promoted field live, not base or spread
// RULE7 - 32-bit pending register, a source request sets its bit
// RULE8 - acknowledge clears pending bit unless source has an event register
// RULE9 - event-register sources clear pending when their events are cleared
// RULE10 - polled software reads pending and clears serviced bits
// RULE11 - writing one clears a pending bit, zero leaves it
// RULE12 - pending register is zero after reset
// RULE13 - serial channel bit positions never move with priority settings
// RULE14 - issuing the error vector sets no pending bit
// RULE15 - acknowledge supplies the highest priority pending source vector
`timescale 1ns/100ps
`include "intc_defines.svh"
module comm_module_interrupt_controller #(
  parameter int N = 32,
  parameter logic [31:0] EVENT_SOURCES = 32'h7c000030 // sources with own event register
) (
  input wire logic mclk,                   // 100 MHz clock
  input wire logic reset,                  // sync, active high
  input wire logic [7:0] addr,             // register address
  input wire logic [31:0] wdata,           // write data
  input wire logic wr,                     // write strobe
  input wire logic rd,                     // read strobe
  output logic [31:0] rdata,               // read data, cycle after rd
  input wire logic [N-1:0] src_req,        // one-cycle source requests
  input wire logic [N-1:0] event_clear,    // event-register source drained
  input wire logic iack,                   // acknowledge strobe
  output logic [7:0] vector,               // acknowledge vector
  output logic vector_valid,               // vector stands, cycle after iack
  output logic int_req,                    // request to core
  output logic irq                         // masked summary interrupt
);
  // five-bit source numbers cover 32 sources only
  if (N != 32) begin : g_bad_n
    $error("controller needs exactly 32 sources");
  end
  ////////////////////////////////////////////////////////////////////
  intc_pkg::reg_req_t req;
  intc_pkg::cfg_t cfg;
  intc_pkg::ack_state_t ack_state;
  logic [N-1:0] pending;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic found;
  logic [4:0] winner;
  logic [N-1:0] ack_clear;
  logic [N-1:0] sw_clear;
  logic err_evt;
  logic ack_evt;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  prio_select #(.N(N)) u_sel (
    .pending(pending),
    .promoted_source_number(cfg.promoted_source_number),
    .spread(cfg.spread),
    .found(found),
    .winner(winner)
  );
  ////////////////////////////////////////////////////////////////////
  // configuration
  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg <= '{vector_base_bits: 3'h0, vbase_written: 1'b0,
               promoted_source_number: `PROMOTE_NONE, spread: 1'b0};
    end else if (req.wr && req.addr == `OFF_CONFIG) begin
      cfg.promoted_source_number <= req.wdata[`CFG_PROMOTE_LSB +: 5]; // [RULE1] [RULE6]
      cfg.vector_base_bits <= req.wdata[`CFG_VBASE_LSB +: 3];
      cfg.vbase_written <= 1'b1; // [RULE4]
      cfg.spread <= req.wdata[`CFG_SPREAD_BIT]; // [RULE5]
    end
  end
  ////////////////////////////////////////////////////////////////////
  // acknowledge: error vector when nothing pending
  assign err_evt = iack && !found;
  assign ack_evt = iack && found;
  always_comb begin
    ack_clear = '0;
    sw_clear = '0;
    if (ack_evt && !EVENT_SOURCES[winner]) begin
      ack_clear[winner] = 1'b1; // [RULE8]
    end
    if (req.wr && req.addr == `OFF_PENDING) begin
      sw_clear = req.wdata; // [RULE11] [RULE10]
    end
  end
  // fixed bit per source, order never remaps storage [RULE13]
  // set beats clear; error vector touches no pending bit [RULE14]
  always_ff @(posedge mclk) begin
    if (reset) begin
      pending <= '0; // [RULE12]
    end else begin
      pending <= (pending & ~(sw_clear | ack_clear | (event_clear & EVENT_SOURCES))) | src_req; // [RULE7] [RULE9]
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      vector <= 8'h00;
      vector_valid <= 1'b0;
      ack_state <= intc_pkg::ack_idle;
    end else begin
      case (ack_state)
        intc_pkg::ack_idle: begin
          vector_valid <= iack;
          if (iack) begin
            ack_state <= intc_pkg::ack_done;
            if (!cfg.vbase_written) begin
              vector <= `UNINIT_VECTOR; // [RULE4]
            end else begin
              vector <= {cfg.vector_base_bits, found ? winner : `ERROR_VECTOR_NUM}; // [RULE3] [RULE15]
            end
          end
        end
        intc_pkg::ack_done: begin
          vector_valid <= iack;
          if (!iack) begin
            ack_state <= intc_pkg::ack_idle;
          end else if (!cfg.vbase_written) begin
            vector <= `UNINIT_VECTOR;
          end else begin
            vector <= {cfg.vector_base_bits, found ? winner : `ERROR_VECTOR_NUM};
          end
        end
        default: ack_state <= intc_pkg::ack_idle;
      endcase
    end
  end
  assign int_req = |pending;
  ////////////////////////////////////////////////////////////////////
  // sticky controller events, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= 2'h0;
    end else begin
      irq_status <= (irq_status & ~((req.wr && req.addr == `OFF_IRQ_STATUS) ? req.wdata[1:0] : 2'h0))
                    | {ack_evt, err_evt};
    end
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask <= 2'h0;
    end else if (req.wr && req.addr == `OFF_MASK) begin
      irq_mask <= req.wdata[1:0];
    end
  end
  assign irq = |(irq_status & irq_mask);
  ////////////////////////////////////////////////////////////////////
  // read port; unmapped reads zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else if (req.rd) begin
      case (req.addr)
        `OFF_CONFIG: rdata <= {16'h0000, cfg.vector_base_bits, cfg.promoted_source_number, 7'h00, cfg.spread};
        `OFF_PENDING: rdata <= pending;
        `OFF_MASK: rdata <= {30'h0, irq_mask};
        `OFF_IRQ_STATUS: rdata <= {30'h0, irq_status};
        default: rdata <= 32'h00000000;
      endcase
    end else begin
      rdata <= 32'h00000000;
    end
  end
endmodule // comm_module_interrupt_controller

/* verif/intc_sva.sv */
`timescale 1ns/100ps
module intc_sva #(
  parameter int N = 32
) (
  input wire logic mclk, // clk
  input wire logic reset, // reset
  input wire logic [7:0] addr, // addr
  input wire logic [31:0] wdata, // data
  input wire logic wr, // write
  input wire logic [N-1:0] src_req, // reqs
  input wire logic iack, // ack
  input wire logic [7:0] vector, // vec
  input wire logic vector_valid, // strobe
  input wire logic int_req // pending
);
  // shadow of the base bits, vectors are judged against it
  logic seen;
  logic [2:0] base;
  always_ff @(posedge mclk) begin
    if (reset) seen <= 1'b0;
    else if (wr && addr == 8'h00) seen <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (wr && addr == 8'h00) base <= wdata[15:13];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  AST_ACK: assert property (iack |=> vector_valid) else $error("no vec");
  AST_NO_EXTRA: assert property (!iack |=> !vector_valid) else $error("stray");
  AST_HOLD: assert property (!iack |=> $stable(vector)) else $error("moved");
  AST_SET: assert property (|src_req |=> int_req) else $error("lost");
  AST_RST: assert property (disable iff (1'b0) reset && !(|src_req) |=> !int_req)
    else $error("rst");
  AST_ERR_NOSET: assert property (iack && !int_req && !(|src_req) |=> !int_req)
    else $error("err set");
  AST_ERR_NUM: assert property (iack && !int_req && seen |=> vector[4:0] == 5'h00)
    else $error("err num");
  AST_UNINIT: assert property (vector_valid && !seen |-> vector == 8'h0f) else $error("uninit");
  AST_BASE: assert property (vector_valid && seen |-> vector[7:5] == base) else $error("base");
endmodule // intc_sva
bind comm_module_interrupt_controller intc_sva #(.N(N)) u_sva (.mclk, .reset, .addr, .wdata, .wr, .src_req,
  .iack, .vector, .vector_valid, .int_req);

/* verif/host_core_model.sv */
`timescale 1ns/100ps
module host_core_model (
  input wire logic mclk, // clk
  input wire logic [7:0] vector, // vec
  input wire logic vector_valid, // strobe
  output logic iack // ack
);
  initial iack = 1'b0;
  ////////////////////////////////////////
  // idles first, so late acks are seen too
  task automatic ack(output logic [7:0] v, output logic ok, input int slow);
    repeat (slow + 1) @(posedge mclk);
    iack <= 1'b1;
    @(posedge mclk);
    iack <= 1'b0;
    // look mid-cycle: the strobe stands one cycle only
    @(negedge mclk);
    v = vector;
    ok = vector_valid;
  endtask
endmodule // host_core_model

/* verif/comm_module_interrupt_controller_tb.sv */
`timescale 1ns/100ps
module comm_module_interrupt_controller_tb;
  logic mclk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, iack, vector_valid, int_req, irq, ok;
  logic [7:0] addr = 8'h00, vector, vec;
  logic [31:0] wdata = 32'h0, src_req = 32'h0, event_clear = 32'h0, rdata, got;
  logic [31:0] cfg [5] = '{32'hbf00, 32'ha300, 32'hbf00, 32'hbf01, 32'hbf00};
  logic [31:0] req [5] = '{32'h80000008, 32'h80000008, 32'h0c000000, 32'h0c000000, 32'h0};
  logic [31:0] pend [5] = '{32'h8, 32'h80000000, 32'h0c000000, 32'h0c000000, 32'h0};
  logic [7:0] expv [5] = '{8'hbf, 8'ha3, 8'hbb, 8'hba, 8'ha0};
  int bad_count = 0, cmp_count = 0;
  // sources with their own event register, as the design defaults
  localparam logic [31:0] EVENT_SRC = 32'h7c000030;
  always #5 mclk = ~mclk;
  comm_module_interrupt_controller DUT (.mclk, .reset, .addr, .wdata, .wr, .rd, .rdata, .src_req,
    .event_clear, .iack, .vector, .vector_valid, .int_req, .irq);
  host_core_model host (.mclk, .vector, .vector_valid, .iack);
  ////////////////////////////////////////
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    got = rdata;
  endtask
  task automatic raise(input logic [31:0] r, input logic [31:0] e);
    @(posedge mclk);
    src_req <= r;
    event_clear <= e;
    @(posedge mclk);
    src_req <= 32'h0;
    event_clear <= 32'h0;
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk);
    reset <= 1'b0;
    foreach (cfg[i]) begin
      wr_reg(8'h00, cfg[i]);
      raise(req[i], 32'h0);
      host.ack(vec, ok, i);
      check({24'h0, vec}, {24'h0, expv[i]});
      check({31'h0, ok}, 32'h1);
      rd_reg(8'h04);
      check(got, pend[i]);
      raise(32'h0, 32'hffffffff);
      rd_reg(8'h04);
      check(got, pend[i] & ~EVENT_SRC);
      wr_reg(8'h04, 32'hffffffff);
      rd_reg(8'h04);
      check(got, 32'h0);
      $display("row %0d end", i);
    end
    raise(32'h80000008, 32'h0);
    wr_reg(8'h04, 32'h8);
    rd_reg(8'h04);
    check(got, 32'h80000000);
    wr_reg(8'h0c, 32'h3);
    wr_reg(8'h08, 32'h2);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    host.ack(vec, ok, 0);
    @(negedge mclk);
    check({31'h0, irq}, 32'h1);
    wr_reg(8'h0c, 32'h2);
    @(negedge mclk);
    check({31'h0, irq}, 32'h0);
    rd_reg(8'h10);
    check(got, 32'h0);
    $display("irq test end");
    raise(32'h2, 32'h0);
    reset <= 1'b1;
    @(posedge mclk);
    reset <= 1'b0;
    rd_reg(8'h04);
    check(got, 32'h0);
    raise(32'h80000000, 32'h0);
    host.ack(vec, ok, 0);
    check({24'h0, vec}, 32'h0f);
    $display("reset test end");
    summarize();
  end
  // about fifteen times the expected run
  initial begin
    #20000;
    bad_count++;
    summarize();
  end
endmodule // comm_module_interrupt_controller_tb
